//--- hw/srpp_pkg.sv
package srpp_pkg;

  // Clocking: link clock is the system clock divided by LINK_DIV
  localparam int CLK_PERIOD_PS = 5000;
  localparam int LINK_DIV      = 4;
  localparam int LINK_HALF     = 2;
  localparam int PHASE_W       = 2;
  localparam int TICK_PS       = CLK_PERIOD_PS * LINK_DIV;

  // Geometry
  localparam int BANK_W                  = 2;
  localparam int ROW_W                   = 12;
  localparam int COL_W                   = 8;
  localparam int DATA_W                  = 32;
  localparam int REQ_ADDR_W              = BANK_W + ROW_W + COL_W;
  localparam int AUTO_PRECHARGE_ADDR_BIT = 10;

  // Device times, in their own units
  localparam int ACT_TO_ACCESS_TIME_NS   = 20;
  localparam int WRITE_RECOVERY_TIME_NS  = 15;
  localparam int PRECHARGE_TIME_NS       = 20;
  localparam int REFRESH_CYCLE_TIME_NS   = 70;
  localparam int ROW_ACTIVE_TIME_NS      = 45;
  localparam int SELF_REFRESH_EXIT_CLKS  = 2;
  localparam int CLK_STABLE_CLKS         = 4;
  localparam int READ_LATENCY            = 2;
  localparam int REFRESH_PERIOD_MS       = 64;
  localparam int REFRESH_ROWS            = 4096;

  localparam int CNT_W = 16;

  // Least time in link ticks, rounded up, never below one
  function automatic int ticks_ceil(input int t_ps);
    int n;
    n = (t_ps + TICK_PS - 1) / TICK_PS;
    return (n < 1) ? 1 : n;
  endfunction

  localparam int RCD_TICKS = ticks_ceil(ACT_TO_ACCESS_TIME_NS * 1000);
  localparam int WR_TICKS  = ticks_ceil(WRITE_RECOVERY_TIME_NS * 1000);
  localparam int RP_TICKS  = ticks_ceil(PRECHARGE_TIME_NS * 1000);
  localparam int RFC_TICKS = ticks_ceil(REFRESH_CYCLE_TIME_NS * 1000);
  localparam int RAS_TICKS = ticks_ceil(ROW_ACTIVE_TIME_NS * 1000);

  // Longest spacing between refreshes, rounded down
  localparam int REF_INTERVAL_NS    = REFRESH_PERIOD_MS * 1000000 / REFRESH_ROWS;
  localparam int REF_INTERVAL_TICKS = REF_INTERVAL_NS * 1000 / TICK_PS;

  localparam logic [CNT_W-1:0] RCD_LOAD   = CNT_W'(RCD_TICKS - 1);
  localparam logic [CNT_W-1:0] WRP_LOAD   = CNT_W'(WR_TICKS + RP_TICKS - 1);
  localparam logic [CNT_W-1:0] RP_LOAD    = CNT_W'(RP_TICKS - 1);
  localparam logic [CNT_W-1:0] RFC_LOAD   = CNT_W'(RFC_TICKS - 1);
  localparam logic [CNT_W-1:0] RAS_LOAD   = CNT_W'(RAS_TICKS - 1);
  localparam logic [CNT_W-1:0] XSR_LOAD   = CNT_W'(SELF_REFRESH_EXIT_CLKS - 1);
  localparam logic [CNT_W-1:0] STAB_LOAD  = CNT_W'(CLK_STABLE_CLKS - 1);
  localparam logic [CNT_W-1:0] RDLAT_LOAD = CNT_W'(READ_LATENCY + 1);

  // Commands as {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_INHIBIT   = 4'hf;
  localparam logic [3:0] CMD_NOP       = 4'h7;
  localparam logic [3:0] CMD_ACTIVE    = 4'h3;
  localparam logic [3:0] CMD_READ      = 4'h5;
  localparam logic [3:0] CMD_WRITE     = 4'h4;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_REFRESH   = 4'h1;

endpackage

//--- hw/srpp_stream_if.sv
`timescale 1ns/100ps
`default_nettype none

interface srpp_stream_if #(
  parameter int WIDTH = 32
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport sink   (input valid, input data, output ready);
  modport source (output valid, output data, input ready);
endinterface

`default_nettype wire

//--- hw/srpp_buf.sv
`timescale 1ns/100ps
`default_nettype none

// Two-entry buffer; the head entry always drives the output
module srpp_buf #(
  parameter int WIDTH = 32
) (
  input  wire logic      clk,
  input  wire logic      resetn,
  srpp_stream_if.sink    fill,
  srpp_stream_if.source  drain
);

  logic [WIDTH-1:0] head;
  logic [WIDTH-1:0] tail;
  logic             head_v;
  logic             tail_v;
  logic [WIDTH-1:0] next_head;
  logic [WIDTH-1:0] next_tail;
  logic             next_head_v;
  logic             next_tail_v;
  logic             push;
  logic             pop;

  assign fill.ready  = ~tail_v;
  assign drain.valid = head_v;
  assign drain.data  = head;

  always_comb begin
    push        = fill.valid & ~tail_v;
    pop         = head_v & drain.ready;
    next_head   = head;
    next_tail   = tail;
    next_head_v = head_v;
    next_tail_v = tail_v;
    if (pop) begin
      if (tail_v) begin
        next_head   = tail;
        next_tail   = fill.data;
        next_tail_v = push;
      end else begin
        next_head   = fill.data;
        next_head_v = push;
      end
    end else if (push) begin
      if (!head_v) begin
        next_head   = fill.data;
        next_head_v = 1'b1;
      end else begin
        next_tail   = fill.data;
        next_tail_v = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      head   <= '0;
      tail   <= '0;
      head_v <= 1'b0;
      tail_v <= 1'b0;
    end else begin
      head   <= next_head;
      tail   <= next_tail;
      head_v <= next_head_v;
      tail_v <= next_tail_v;
    end
  end

endmodule // srpp_buf

`default_nettype wire

//--- hw/srpp_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

module srpp_ctrl #(
  parameter int REF_INTERVAL = srpp_pkg::REF_INTERVAL_TICKS
) (
  input  wire logic                            clk,
  input  wire logic                            resetn,
  input  wire logic                            req_valid,
  input  wire logic                            req_write,
  input  wire logic [srpp_pkg::REQ_ADDR_W-1:0] req_addr,
  input  wire logic [srpp_pkg::DATA_W-1:0]     req_wdata,
  output logic                                 req_ready,
  output logic [srpp_pkg::DATA_W-1:0]          rd_data,
  output logic                                 rd_valid,
  input  wire logic                            rd_ready,
  input  wire logic                            pd_req,
  input  wire logic                            sr_req,
  output logic                                 pd_active,
  output logic                                 sr_active,
  output logic                                 sdram_clk,
  output logic                                 sdram_cke,
  output logic                                 sdram_cs_n,
  output logic                                 sdram_ras_n,
  output logic                                 sdram_cas_n,
  output logic                                 sdram_we_n,
  output logic [srpp_pkg::BANK_W-1:0]          sdram_ba,
  output logic [srpp_pkg::ROW_W-1:0]           sdram_addr,
  input  wire logic [srpp_pkg::DATA_W-1:0]     sdram_dq_in,
  output logic [srpp_pkg::DATA_W-1:0]          sdram_dq_out,
  output logic                                 sdram_dq_oe
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_ACT_WAIT, ST_RD_WAIT, ST_WR_WAIT, ST_PRE_WAIT,
    ST_REF_WAIT, ST_PD, ST_SR_HOLD, ST_SR_CLK, ST_SR_EXIT
  } srpp_state_e;

  localparam logic [srpp_pkg::PHASE_W-1:0] PH_LAST = srpp_pkg::PHASE_W'(srpp_pkg::LINK_DIV - 1);
  localparam logic [srpp_pkg::PHASE_W-1:0] PH_HALF = srpp_pkg::PHASE_W'(srpp_pkg::LINK_HALF);
  localparam logic [srpp_pkg::CNT_W-1:0]   REF_LAST = srpp_pkg::CNT_W'(REF_INTERVAL - 1);

  srpp_state_e                    state;
  srpp_state_e                    next_state;
  logic [srpp_pkg::PHASE_W-1:0]   phase;
  logic [srpp_pkg::PHASE_W-1:0]   next_phase;
  logic [srpp_pkg::CNT_W-1:0]     cnt;
  logic [srpp_pkg::CNT_W-1:0]     next_cnt;
  logic [srpp_pkg::CNT_W-1:0]     ref_cnt;
  logic [srpp_pkg::CNT_W-1:0]     next_ref_cnt;
  logic                           ref_due;
  logic                           next_ref_due;
  logic                           for_sr;
  logic                           next_for_sr;
  logic                           clk_run;
  logic                           next_clk_run;
  logic                           next_sdram_clk;
  logic                           next_cke;
  logic [3:0]                     cmd;
  logic [3:0]                     next_cmd;
  logic [srpp_pkg::BANK_W-1:0]    next_ba;
  logic [srpp_pkg::ROW_W-1:0]     next_addr;
  logic [srpp_pkg::COL_W-1:0]     col;
  logic [srpp_pkg::COL_W-1:0]     next_col;
  logic                           is_write;
  logic                           next_is_write;
  logic [srpp_pkg::DATA_W-1:0]    wdata;
  logic [srpp_pkg::DATA_W-1:0]    next_wdata;
  logic [srpp_pkg::DATA_W-1:0]    next_dq_out;
  logic                           next_dq_oe;
  logic                           next_req_ready;
  logic                           next_pd_active;
  logic                           next_sr_active;
  logic [srpp_pkg::DATA_W-1:0]    dq_q1;
  logic [srpp_pkg::DATA_W-1:0]    dq_q2;
  logic                           tick;
  logic                           accept;
  logic                           cap;
  logic                           ref_set;
  logic                           ref_clr;
  logic                           buf_in_ready;

  srpp_stream_if #(.WIDTH(srpp_pkg::DATA_W)) fill_if ();
  srpp_stream_if #(.WIDTH(srpp_pkg::DATA_W)) drain_if ();

  assign fill_if.valid  = cap;
  assign fill_if.data   = dq_q2;
  assign buf_in_ready   = fill_if.ready;
  assign drain_if.ready = rd_ready;
  assign rd_valid       = drain_if.valid;
  assign rd_data        = drain_if.data;

  srpp_buf #(.WIDTH(srpp_pkg::DATA_W)) u_rd_buf (
    .clk    (clk),
    .resetn (resetn),
    .fill   (fill_if),
    .drain  (drain_if)
  );

  assign sdram_cs_n  = cmd[3];
  assign sdram_ras_n = cmd[2];
  assign sdram_cas_n = cmd[1];
  assign sdram_we_n  = cmd[0];

  // Commands change at tick, one system clock (a quarter link period) before the rising edge
  assign tick   = (phase == '0);
  assign accept = tick & req_ready & req_valid;

  always_comb begin
    next_phase     = (phase == PH_LAST) ? '0 : phase + 1'b1;
    next_state     = state;
    next_cnt       = cnt;
    next_ref_cnt   = ref_cnt;
    next_for_sr    = for_sr;
    next_clk_run   = clk_run;
    next_cke       = sdram_cke;
    next_cmd       = cmd;
    next_ba        = sdram_ba;
    next_addr      = sdram_addr;
    next_col       = col;
    next_is_write  = is_write;
    next_wdata     = wdata;
    next_dq_out    = sdram_dq_out;
    next_dq_oe     = sdram_dq_oe;
    next_sr_active = sr_active;
    next_pd_active = pd_active;
    cap            = 1'b0;
    ref_set        = 1'b0;
    ref_clr        = 1'b0;
    if (tick) begin
      if (ref_cnt >= REF_LAST) begin
        next_ref_cnt = '0;
        ref_set      = 1'b1;
      end else begin
        next_ref_cnt = ref_cnt + 1'b1;
      end
    end
    if (tick) begin
      next_cmd   = srpp_pkg::CMD_NOP;
      next_dq_oe = 1'b0;
      if (cnt != '0) begin
        next_cnt = cnt - 1'b1;
      end
      unique case (state)
        ST_IDLE: begin
          if (accept) begin
            next_cmd      = srpp_pkg::CMD_ACTIVE;
            next_ba       = req_addr[srpp_pkg::REQ_ADDR_W-1 -: srpp_pkg::BANK_W];
            next_addr     = req_addr[srpp_pkg::COL_W +: srpp_pkg::ROW_W];
            next_col      = req_addr[srpp_pkg::COL_W-1:0];
            next_is_write = req_write;
            next_wdata    = req_wdata;
            next_cnt      = srpp_pkg::RCD_LOAD;
            next_state    = ST_ACT_WAIT;
          end else if (ref_due || sr_req) begin
            next_cmd    = srpp_pkg::CMD_PRECHARGE;
            next_addr   = '0;
            next_addr[srpp_pkg::AUTO_PRECHARGE_ADDR_BIT] = 1'b1;
            next_for_sr = ~ref_due;
            next_cnt    = srpp_pkg::RP_LOAD;
            next_state  = ST_PRE_WAIT;
          end else if (pd_req) begin
            // NOP with enable low, banks idle
            next_cke       = 1'b0;
            next_pd_active = 1'b1;
            next_state     = ST_PD;
          end
        end
        ST_ACT_WAIT: begin
          if (cnt == '0) begin
            next_addr = '0;
            next_addr[srpp_pkg::COL_W-1:0] = col;
            next_addr[srpp_pkg::AUTO_PRECHARGE_ADDR_BIT] = 1'b1;
            if (is_write) begin
              next_cmd    = srpp_pkg::CMD_WRITE;
              next_dq_out = wdata;
              next_dq_oe  = 1'b1;
              next_cnt    = srpp_pkg::WRP_LOAD;
              next_state  = ST_WR_WAIT;
            end else begin
              next_cmd   = srpp_pkg::CMD_READ;
              next_cnt   = srpp_pkg::RDLAT_LOAD;
              next_state = ST_RD_WAIT;
            end
          end
        end
        ST_RD_WAIT: begin
        end
        ST_WR_WAIT: begin
          if (cnt == '0) begin
            next_state = ST_IDLE;
          end
        end
        ST_PRE_WAIT: begin
          if (cnt == '0) begin
            next_cmd = srpp_pkg::CMD_REFRESH;
            ref_clr  = ~for_sr;
            if (for_sr) begin
              // refresh with enable low enters self refresh
              next_cke       = 1'b0;
              next_sr_active = 1'b1;
              next_cnt       = srpp_pkg::RAS_LOAD;
              next_state     = ST_SR_HOLD;
            end else begin
              next_cnt   = srpp_pkg::RFC_LOAD;
              next_state = ST_REF_WAIT;
            end
          end
        end
        ST_REF_WAIT: begin
          if (cnt == '0) begin
            next_state = ST_IDLE;
          end
        end
        ST_PD: begin
          // NOP with enable high ends power-down
          if (ref_due || !pd_req) begin
            next_cke       = 1'b1;
            next_pd_active = 1'b0;
            next_state     = ST_IDLE;
          end
        end
        ST_SR_HOLD: begin
          // link clock stopped, held at least row active time
          next_clk_run = 1'b0;
          if (cnt == '0 && !sr_req) begin
            next_clk_run = 1'b1;
            next_cnt     = srpp_pkg::STAB_LOAD;
            next_state   = ST_SR_CLK;
          end
        end
        ST_SR_CLK: begin
          // clock runs stable before enable rises
          if (cnt == '0) begin
            next_cke   = 1'b1;
            next_cnt   = srpp_pkg::XSR_LOAD;
            next_state = ST_SR_EXIT;
          end
        end
        ST_SR_EXIT: begin
          if (cnt == '0) begin
            next_sr_active = 1'b0;
            next_state     = ST_IDLE;
          end
        end
      endcase
    end
    if (state == ST_RD_WAIT && cnt == '0 && phase == PH_HALF) begin
      cap        = 1'b1;
      next_state = ST_IDLE;
    end
    if (tick && state == ST_SR_EXIT && cnt == '0) begin
      next_ref_cnt = '0;
      ref_clr      = 1'b1;
      ref_set      = 1'b0;
    end
    // New due wins over a clear in the same cycle
    next_ref_due   = ref_set | (ref_due & ~ref_clr);
    // no new access while refresh is due
    next_req_ready = (phase == PH_LAST) && (state == ST_IDLE) && !ref_due && !sr_req &&
                     !pd_req && buf_in_ready;
    next_sdram_clk = next_clk_run && (next_phase >= PH_HALF);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dq_q1 <= '0;
      dq_q2 <= '0;
    end else begin
      dq_q1 <= sdram_dq_in;
      dq_q2 <= dq_q1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state        <= ST_IDLE;
      phase        <= '0;
      cnt          <= '0;
      ref_cnt      <= '0;
      ref_due      <= 1'b0;
      for_sr       <= 1'b0;
      clk_run      <= 1'b1;
      sdram_clk    <= 1'b0;
      sdram_cke    <= 1'b1;
      cmd          <= srpp_pkg::CMD_INHIBIT;
      sdram_ba     <= '0;
      sdram_addr   <= '0;
      col          <= '0;
      is_write     <= 1'b0;
      wdata        <= '0;
      sdram_dq_out <= '0;
      sdram_dq_oe  <= 1'b0;
      req_ready    <= 1'b0;
      pd_active    <= 1'b0;
      sr_active    <= 1'b0;
    end else begin
      state        <= next_state;
      phase        <= next_phase;
      cnt          <= next_cnt;
      ref_cnt      <= next_ref_cnt;
      ref_due      <= next_ref_due;
      for_sr       <= next_for_sr;
      clk_run      <= next_clk_run;
      sdram_clk    <= next_sdram_clk;
      sdram_cke    <= next_cke;
      cmd          <= next_cmd;
      sdram_ba     <= next_ba;
      sdram_addr   <= next_addr;
      col          <= next_col;
      is_write     <= next_is_write;
      wdata        <= next_wdata;
      sdram_dq_out <= next_dq_out;
      sdram_dq_oe  <= next_dq_oe;
      req_ready    <= next_req_ready;
      pd_active    <= next_pd_active;
      sr_active    <= next_sr_active;
    end
  end

endmodule // srpp_ctrl

`default_nettype wire

//--- sim/srpp_ctrl_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module srpp_ctrl_monitor #(
  parameter int REF_INTERVAL = 40
) (
  input wire logic                       clk,
  input wire logic                       resetn,
  input wire logic                       pd_active,
  input wire logic                       sr_active,
  input wire logic                       sdram_clk,
  input wire logic                       sdram_cke,
  input wire logic                       sdram_cs_n,
  input wire logic                       sdram_ras_n,
  input wire logic                       sdram_cas_n,
  input wire logic                       sdram_we_n,
  input wire logic [srpp_pkg::ROW_W-1:0] sdram_addr
);
  logic [3:0]  cmd;
  logic        nop_c;
  logic [15:0] low_cnt, next_low_cnt, pd_cnt, next_pd_cnt, gap_cnt, next_gap_cnt;

  assign cmd   = {sdram_cs_n, sdram_ras_n, sdram_cas_n, sdram_we_n};
  assign nop_c = (cmd == srpp_pkg::CMD_NOP) || (cmd == srpp_pkg::CMD_INHIBIT);

  // Run lengths: clock enable low, power-down, time since last refresh
  always_comb begin
    next_low_cnt = sdram_cke ? 16'h0 : low_cnt + 16'h1;
    next_pd_cnt  = pd_active ? pd_cnt + 16'h1 : 16'h0;
    next_gap_cnt = (cmd == srpp_pkg::CMD_REFRESH || sr_active) ? 16'h0 : gap_cnt + 16'h1;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      low_cnt <= 16'h0;
      pd_cnt  <= 16'h0;
      gap_cnt <= 16'h0;
    end else begin
      low_cnt <= next_low_cnt;
      pd_cnt  <= next_pd_cnt;
      gap_cnt <= next_gap_cnt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  pre_before_ref_a: assert property ($rose(cmd == srpp_pkg::CMD_REFRESH) |->
    $past(cmd, 4) == srpp_pkg::CMD_PRECHARGE && $past(sdram_addr[10], 4))
    else $error("refresh without precharge all one tick before");
  rfc_nop_only_a: assert property (
    $rose(cmd == srpp_pkg::CMD_REFRESH && sdram_cke) |-> ##4 nop_c [*8] ##1 nop_c [*4])
    else $error("command issued inside refresh cycle time");
  sr_min_hold_a: assert property ($rose(sdram_cke) && sr_active |->
    low_cnt >= 16'(srpp_pkg::RAS_TICKS * 4))
    else $error("self refresh left too early");
  sr_clk_stable_a: assert property ($rose(sdram_cke) && sr_active |->
    $past(sdram_clk, 1) != $past(sdram_clk, 3) && $past(sdram_clk, 13) != $past(sdram_clk, 15))
    else $error("clock not running before clock enable rise");
  sr_exit_nop_a: assert property ($rose(sdram_cke) && sr_active |-> nop_c [*8])
    else $error("no two NOP periods after self refresh exit");
  pd_entry_a: assert property ($rose(pd_active) |->
    !sdram_cke && cmd == srpp_pkg::CMD_NOP)
    else $error("power-down entered without NOP and low enable");
  pd_exit_a: assert property ($fell(pd_active) |-> sdram_cke && nop_c)
    else $error("power-down left without NOP and high enable");
  pd_max_a: assert property (pd_active |-> pd_cnt <= 16'(REF_INTERVAL * 4 + 8))
    else $error("power-down outlasts refresh interval");
  ref_gap_a: assert property ($rose(cmd == srpp_pkg::CMD_REFRESH) |->
    gap_cnt <= 16'(REF_INTERVAL * 4 + 96))
    else $error("refresh spacing too long");
  ap_bit_a: assert property (
    cmd == srpp_pkg::CMD_READ || cmd == srpp_pkg::CMD_WRITE |-> sdram_addr[10])
    else $error("access without auto precharge bit");

  cover property ($rose(pd_active));
  cover property ($rose(sr_active));
  cover property ($rose(cmd == srpp_pkg::CMD_REFRESH && sdram_cke));
endmodule // srpp_ctrl_monitor

bind srpp_ctrl srpp_ctrl_monitor #(.REF_INTERVAL(REF_INTERVAL)) i_monitor (
  .clk(clk), .resetn(resetn), .pd_active(pd_active), .sr_active(sr_active),
  .sdram_clk(sdram_clk), .sdram_cke(sdram_cke), .sdram_cs_n(sdram_cs_n),
  .sdram_ras_n(sdram_ras_n), .sdram_cas_n(sdram_cas_n), .sdram_we_n(sdram_we_n),
  .sdram_addr(sdram_addr)
);

`default_nettype wire

//--- sim/srpp_sdram_model.sv
`timescale 1ns/100ps
`default_nettype none

module srpp_sdram_model (
  input  wire logic                        sdram_clk,
  input  wire logic                        sdram_cke,
  input  wire logic                        sdram_cs_n,
  input  wire logic                        sdram_ras_n,
  input  wire logic                        sdram_cas_n,
  input  wire logic                        sdram_we_n,
  input  wire logic [srpp_pkg::BANK_W-1:0] sdram_ba,
  input  wire logic [srpp_pkg::ROW_W-1:0]  sdram_addr,
  input  wire logic [srpp_pkg::DATA_W-1:0] sdram_dq_out,
  input  wire logic                        sdram_dq_oe,
  output logic [srpp_pkg::DATA_W-1:0]      sdram_dq_in,
  output logic                             in_sr,
  output int                               refresh_count,
  output int                               viol_count
);
  logic [31:0] mem [logic [21:0]];
  logic [11:0] row [4];
  logic [3:0]  open_bank;
  logic [11:0] refresh_row;
  logic        cke_prev;
  logic [1:0]  pipe_v;
  logic [1:0][31:0] pipe_d;
  logic [3:0]  cmd;
  logic [21:0] key;

  assign cmd = {sdram_cs_n, sdram_ras_n, sdram_cas_n, sdram_we_n};
  assign key = {sdram_ba, row[sdram_ba], sdram_addr[7:0]};

  initial begin
    sdram_dq_in = 32'h0;
    in_sr = 1'b0;
    refresh_count = 0;
    viol_count = 0;
    open_bank = 4'h0;
    refresh_row = 12'h0;
    cke_prev = 1'b1;
    pipe_v = 2'h0;
    pipe_d = 64'h0;
  end

  // internal refresh clock with no external clock
  always #80 if (in_sr) begin
    refresh_row = refresh_row + 12'h1;
    refresh_count++;
  end

  always @(posedge sdram_clk) begin
    // edge after low enable is skipped, outputs held
    if (cke_prev && !in_sr) begin
      // single-word bursts, read data two edges after command
      sdram_dq_in <= pipe_v[1] ? pipe_d[1] : ~sdram_dq_in;
      pipe_v <= {pipe_v[0], (cmd == srpp_pkg::CMD_READ)};
      pipe_d <= {pipe_d[0], (mem.exists(key) ? mem[key] : {10'h2a5, ~key})};
      case (cmd)
        srpp_pkg::CMD_ACTIVE: begin
          row[sdram_ba] <= sdram_addr;
          open_bank[sdram_ba] <= 1'b1;
        end
        srpp_pkg::CMD_READ, srpp_pkg::CMD_WRITE: begin
          if (!open_bank[sdram_ba]) viol_count++;
          if (cmd == srpp_pkg::CMD_WRITE && sdram_dq_oe) mem[key] = sdram_dq_out;
          // bank closes after access only with the address bit
          if (sdram_addr[10]) open_bank[sdram_ba] <= 1'b0;
        end
        srpp_pkg::CMD_PRECHARGE: begin
          if (sdram_addr[10]) open_bank <= 4'h0;
          else open_bank[sdram_ba] <= 1'b0;
        end
        srpp_pkg::CMD_REFRESH: begin
          if (|open_bank) viol_count++;
          // row comes from the internal counter, address ignored
          refresh_row <= refresh_row + 12'h1;
          refresh_count++;
          if (!sdram_cke) in_sr <= 1'b1;
        end
        default: ;
      endcase
    end
    // high enable resumes at the next edge
    if (sdram_cke) in_sr <= 1'b0;
    cke_prev <= sdram_cke;
  end
endmodule // srpp_sdram_model

`default_nettype wire

//--- sim/test_sdram_refresh_power_precharge.sv
`timescale 1ns/100ps
`default_nettype none

module test_sdram_refresh_power_precharge;
  localparam int REF_INT = 40;
  logic        clk, resetn, req_valid, req_write, rd_ready, pd_req, sr_req, stall, seen;
  logic        req_ready, rd_valid, pd_active, sr_active, in_sr;
  logic        s_clk, s_cke, s_cs_n, s_ras_n, s_cas_n, s_we_n, s_oe;
  logic [1:0]  s_ba;
  logic [11:0] s_addr;
  logic [21:0] req_addr;
  logic [31:0] req_wdata, rd_data, s_dq_in, s_dq_out, d;
  logic [21:0] adr [8];
  logic [31:0] shadow [logic [21:0]];
  logic [31:0] exp_q [$];
  int          errors, comparisons, refresh_count, viol_count, rc, seed;

  srpp_ctrl #(.REF_INTERVAL(REF_INT)) i_dut (
    .clk(clk), .resetn(resetn), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .pd_req(pd_req), .sr_req(sr_req),
    .pd_active(pd_active), .sr_active(sr_active), .sdram_clk(s_clk), .sdram_cke(s_cke),
    .sdram_cs_n(s_cs_n), .sdram_ras_n(s_ras_n), .sdram_cas_n(s_cas_n), .sdram_we_n(s_we_n),
    .sdram_ba(s_ba), .sdram_addr(s_addr), .sdram_dq_in(s_dq_in), .sdram_dq_out(s_dq_out),
    .sdram_dq_oe(s_oe));

  srpp_sdram_model i_model (
    .sdram_clk(s_clk), .sdram_cke(s_cke), .sdram_cs_n(s_cs_n), .sdram_ras_n(s_ras_n),
    .sdram_cas_n(s_cas_n), .sdram_we_n(s_we_n), .sdram_ba(s_ba), .sdram_addr(s_addr),
    .sdram_dq_out(s_dq_out), .sdram_dq_oe(s_oe), .sdram_dq_in(s_dq_in), .in_sr(in_sr),
    .refresh_count(refresh_count), .viol_count(viol_count));

  always #2.5 clk = ~clk;
  task automatic finish_test();
    $display("Comparisons %0d, errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic ok, input string what);
    comparisons++;
    if (ok !== 1'b1) begin
      errors++;
      $display("ERROR %0t %s", $time, what);
    end
  endtask

  function automatic logic flag(input int k);
    return (k == 0) ? pd_active : (k == 1) ? sr_active : in_sr;
  endfunction

  task automatic wait_flag(input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (flag(k) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    check(flag(k) === v, "state flag not reached in time");
  endtask

  // Holds the request until taken, then notes the expected read word
  task automatic do_req(input logic wr, input logic [21:0] a, input logic [31:0] dat);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= dat;
    @(posedge clk);
    while (req_ready !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    check(n < 2000, "request not taken");
    if (wr) shadow[a] = dat;
    else exp_q.push_back(shadow[a]);
    req_valid <= 1'b0;
    @(posedge clk);
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    check(exp_q.size() == 0, "read words missing");
  endtask

  always @(posedge clk) begin
    if (stall) rd_ready <= 1'($urandom_range(0, 1));
  end

  always @(posedge clk) begin
    if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
      comparisons++;
      if (exp_q.size() == 0 || rd_data !== exp_q[0]) begin
        errors++;
        $display("ERROR %0t read word mismatch", $time);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end

  initial begin
    #100000;
    errors++;
    $display("ERROR %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    {clk, resetn, req_valid, req_write, pd_req, sr_req, stall} = 7'h0;
    rd_ready = 1'b1;
    req_addr = 22'h0;
    req_wdata = 32'h0;
    seed = $urandom(25432);
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    // Random writes across banks, all finished before the first refresh falls due
    for (int i = 0; i < 8; i++) begin
      adr[i] = 22'($urandom);
      d = $urandom;
      do_req(1'b1, adr[i], d);
    end
    // Stalled consumer fills the buffer, a third read must wait
    rd_ready <= 1'b0;
    for (int i = 0; i < 2; i++) do_req(1'b0, adr[i], 32'h0);
    req_valid <= 1'b1;
    req_addr <= adr[2];
    seen = 1'b0;
    repeat (100) begin
      @(posedge clk);
      seen = seen | (req_ready === 1'b1);
    end
    check(!seen && rd_valid === 1'b1, "read taken with full buffer");
    stall <= 1'b1;
    for (int i = 2; i < 8; i++) do_req(1'b0, adr[i], 32'h0);
    drain();
    stall <= 1'b0;
    @(posedge clk);
    rd_ready <= 1'b1;
    // Power-down, left on its own when a refresh falls due
    pd_req <= 1'b1;
    wait_flag(0, 1'b1, 100);
    check(s_cke === 1'b0, "clock enable high in power-down");
    rc = refresh_count;
    wait_flag(0, 1'b0, REF_INT * 4 + 20);
    pd_req <= 1'b0;
    repeat (60) @(posedge clk);
    check(refresh_count > rc, "no refresh after power-down exit");
    // Self refresh entry, hold, exit and resumed refresh
    sr_req <= 1'b1;
    wait_flag(2, 1'b1, 400);
    rc = refresh_count;
    repeat (300) @(posedge clk);
    check(s_clk === 1'b0 && s_cke === 1'b0, "link clock or enable active");
    check(refresh_count > rc, "no internal refresh");
    sr_req <= 1'b0;
    wait_flag(1, 1'b0, 400);
    check(in_sr === 1'b0 && s_cke === 1'b1, "self refresh not left");
    rc = refresh_count;
    repeat (REF_INT * 8) @(posedge clk);
    check(refresh_count > rc, "refresh not resumed");
    do_req(1'b0, adr[0], 32'h0);
    drain();
    check(viol_count == 0, "bank state violated");
    finish_test();
  end
endmodule // test_sdram_refresh_power_precharge

`default_nettype wire
